/* logic/card_ctrl_host.sv */
// Mainframe-side controller for the serial relay and digital I/O card
// Operation
// R01 - Read identification record before using card
// R02 - Start: data falls while ID clock high
// R03 - Send location, get acknowledge, then data
// R04 - Acknowledge each byte; memory sends next location
// R05 - Stop: data rises while ID clock high
// R06 - Shift five relay bytes, one per clock
// R07 - Card chains its driver registers end to end
// R08 - Strobe after relay bytes latches relay drivers
// R09 - Card driver output low energizes relay
// R10 - Drivers only act while enable is active
// R11 - Card boosts relay supply after closing strobe
// R12 - Shift two output-channel bytes on own clock
// R13 - Strobe transfers output-channel pattern to drivers
// R14 - Card output polarity follows channel configuration
// R15 - Card loads inputs into eight and two
// R16 - Strobe captures inputs, shift clock reads two bytes
// R17 - Card input lead register refills from chain
// R18 - Drivers disabled during power-up and power-down
// R19 - Processor reset holds safeguard, disables drivers
// R20 - After reset hold, drivers still disabled
// R21 - First valid strobe enables drivers until reset
// R22 - Safeguard output disables every card driver
// R23 - ID data changes only while clock low
// R24 - Shift on rising edge, latch on strobe
// R25 - Card relay supply steady low, briefly raised
// R26 - Relay clock and data only during update
`timescale 1ns/1ps
module card_ctrl_host #(
   parameter int HOLD_CYCLES = card_pkg::PRESET_HOLD_CYC
) (
   input  wire logic        core_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [39:0] relay_pattern_i,
   input  wire logic [15:0] out_pattern_i,
   input  wire logic        update_i,
   input  wire logic        read_in_i,
   input  wire logic [3:0]  id_rd_addr_i,
   output logic      [7:0]  id_rd_data_o,
   output logic             id_ready_o,
   output logic             id_error_o,
   output logic             busy_o,
   output logic      [15:0] in_data_o,
   output logic             in_valid_o,
   output logic             driver_disable_o,
   output logic             strobe_o,
   output logic             id_serial_clock_o,
   input  wire logic        id_serial_data_i,
   output logic             id_serial_data_o,
   output logic             id_serial_data_oe_o,
   output logic             out_serial_data_o,
   output logic             relay_shift_clock_o,
   output logic             output_channel_shift_clock_o,
   output logic             input_shift_clock_o,
   input  wire logic        in_serial_data_i
);
   typedef enum logic [2:0] {ST_HOLD, ST_ID, ST_IDLE, ST_SHIFT,
                             ST_STROBE, ST_INSHIFT} host_state_t;
   localparam logic [card_pkg::HOLD_W-1:0] HOLD_LOAD =
      card_pkg::HOLD_W'(HOLD_CYCLES - 1);

   host_state_t                 state, next_state;
   logic [card_pkg::HOLD_W-1:0] hold, next_hold;
   logic [card_pkg::TMR_W-1:0]  tmr, next_tmr;
   logic                        half, next_half;
   logic [5:0]                  bit_cnt, next_bit;
   logic [55:0]                 chain, next_chain;
   logic                        rd_op, next_rd_op;
   logic                        next_strobe, next_rclk, next_oclk;
   logic                        next_iclk, next_odata, next_disable;
   logic                        next_busy, next_in_vld;
   logic [15:0]                 next_in_data;
   logic                        next_id_ok, next_id_err, id_go;
   logic                        next_id_go;
   logic [4:0]                  wptr, next_wptr;
   logic [1:0]                  meta, sync;
   logic [7:0]                  id_mem [card_pkg::ID_BYTES];
   logic                        tick;

   id_link_if lnk ();
   assign lnk.start = id_go;

   function automatic logic last_bit(input logic [5:0] n, input int bits);
      return n == 6'(bits - 1);
   endfunction

   id_reader u_id_reader (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .sda_i      (sync[0]),
      .scl_o      (id_serial_clock_o),
      .sda_oe_o   (id_serial_data_oe_o),
      .lnk        (lnk)
   );

   // Pins from the card are asynchronous to core_clk_i
   always_ff @(posedge core_clk_i) begin
      meta <= {in_serial_data_i, id_serial_data_i};
      sync <= meta;
   end

   assign tick = (tmr == '0);

   always_comb begin
      next_state = state;
      next_hold = hold;
      next_tmr = tmr;
      next_half = half;
      next_bit = bit_cnt;
      next_chain = chain;
      next_rd_op = rd_op;
      next_strobe = strobe_o;
      next_rclk = relay_shift_clock_o;
      next_oclk = output_channel_shift_clock_o;
      next_iclk = input_shift_clock_o;
      next_odata = out_serial_data_o;
      next_disable = driver_disable_o;
      next_busy = busy_o;
      next_in_vld = 1'b0;
      next_in_data = in_data_o;
      next_id_ok = id_ready_o;
      next_id_err = id_error_o;
      next_id_go = 1'b0;
      next_wptr = wptr + 5'(lnk.byte_vld);
      if (state == ST_HOLD || state == ST_ID || state == ST_IDLE)
         next_tmr = card_pkg::SHIFT_HALF_LOAD;
      else if (tick)
         next_tmr = card_pkg::SHIFT_HALF_LOAD;
      else
         next_tmr = tmr - 1'b1;
      case (state)
         ST_HOLD: begin
            // Preset held: drivers stay off through power-up
            next_disable = 1'b1; // R19
            next_hold = hold - 1'b1;
            if (hold == '0) begin
               next_state = ST_ID; // R20
               next_id_go = 1'b1;
            end
         end
         ST_ID: begin
            if (lnk.done && !id_go) begin
               next_id_ok = !lnk.fail; // R01
               next_id_err = lnk.fail;
               next_busy = 1'b0;
               next_state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            // Card stays untouched until its record has been read
            if (id_ready_o && update_i) begin
               next_chain = {relay_pattern_i, out_pattern_i};
               next_odata = relay_pattern_i[39];
               next_rd_op = 1'b0;
               next_bit = '0;
               next_half = 1'b0;
               next_busy = 1'b1;
               next_state = ST_SHIFT; // R01
            end else if (id_ready_o && read_in_i) begin
               next_rd_op = 1'b1;
               next_half = 1'b0;
               next_busy = 1'b1;
               next_strobe = 1'b1; // R16
               next_state = ST_STROBE;
            end
         end
         ST_SHIFT: begin
            if (tick && !half) begin
               next_half = 1'b1;
               // Rising edge shifts the bit in
               if (bit_cnt < 6'(card_pkg::RELAY_BITS))
                  next_rclk = 1'b1; // R06
               else
                  next_oclk = 1'b1; // R12
            end else if (tick) begin
               next_half = 1'b0;
               next_rclk = 1'b0;
               next_oclk = 1'b0;
               next_chain = {chain[54:0], 1'b0};
               next_odata = chain[54]; // R24
               next_bit = bit_cnt + 1'b1;
               if (last_bit(bit_cnt, card_pkg::CHAIN_BITS)) begin
                  next_bit = '0;
                  next_odata = 1'b0; // R26
                  next_strobe = 1'b1; // R08 R13
                  // Latched pattern is real: enable the drivers now
                  next_disable = 1'b0; // R21
                  next_state = ST_STROBE;
               end
            end
         end
         ST_STROBE: begin
            if (tick && !half) begin
               next_strobe = 1'b0;
               next_half = 1'b1;
            end else if (tick) begin
               next_half = 1'b0;
               next_bit = '0;
               next_state = rd_op ? ST_INSHIFT : ST_IDLE;
               next_busy = rd_op;
            end
         end
         ST_INSHIFT: begin
            if (tick && !half) begin
               // Sample before the edge that brings the next bit
               next_chain = {chain[54:0], sync[1]}; // R16
               next_iclk = 1'b1;
               next_half = 1'b1;
            end else if (tick) begin
               next_iclk = 1'b0;
               next_half = 1'b0;
               next_bit = bit_cnt + 1'b1;
               if (last_bit(bit_cnt, card_pkg::IN_BITS)) begin
                  next_in_data = chain[15:0]; // R16
                  next_in_vld = 1'b1;
                  next_busy = 1'b0;
                  next_state = ST_IDLE;
               end
            end
         end
         default: next_state = ST_HOLD;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state <= ST_HOLD;
         hold <= HOLD_LOAD;
         tmr <= card_pkg::SHIFT_HALF_LOAD;
         half <= 1'b0;
         bit_cnt <= '0;
         chain <= '0;
         rd_op <= 1'b0;
         strobe_o <= 1'b0;
         relay_shift_clock_o <= 1'b0;
         output_channel_shift_clock_o <= 1'b0;
         input_shift_clock_o <= 1'b0;
         out_serial_data_o <= 1'b0;
         driver_disable_o <= 1'b1; // R19 R18
         busy_o <= 1'b1;
         in_valid_o <= 1'b0;
         in_data_o <= '0;
         id_ready_o <= 1'b0;
         id_error_o <= 1'b0;
         id_go <= 1'b0;
         wptr <= '0;
      end else begin
         state <= next_state;
         hold <= next_hold;
         tmr <= next_tmr;
         half <= next_half;
         bit_cnt <= next_bit;
         chain <= next_chain;
         rd_op <= next_rd_op;
         strobe_o <= next_strobe;
         relay_shift_clock_o <= next_rclk;
         output_channel_shift_clock_o <= next_oclk;
         input_shift_clock_o <= next_iclk;
         out_serial_data_o <= next_odata;
         driver_disable_o <= next_disable;
         busy_o <= next_busy;
         in_valid_o <= next_in_vld;
         in_data_o <= next_in_data;
         id_ready_o <= next_id_ok;
         id_error_o <= next_id_err;
         id_go <= next_id_go;
         wptr <= next_wptr;
      end
   end

   // Open-drain pin: only ever pulled low
   always_ff @(posedge core_clk_i) begin
      id_serial_data_o <= 1'b0;
      if (lnk.byte_vld && wptr < 5'(card_pkg::ID_BYTES))
         id_mem[wptr[3:0]] <= lnk.byte_data; // R04
      id_rd_data_o <= id_mem[id_rd_addr_i];
   end

   // Edge counters read only by the checks below
   logic [5:0] rclk_n, oclk_n, iclk_n;
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || state == ST_IDLE) begin
         rclk_n <= '0;
         oclk_n <= '0;
         iclk_n <= '0;
      end else begin
         rclk_n <= rclk_n + 6'(next_rclk && !relay_shift_clock_o);
         oclk_n <= oclk_n + 6'(next_oclk && !output_channel_shift_clock_o);
         iclk_n <= iclk_n + 6'(next_iclk && !input_shift_clock_o);
      end
   end

   sequence strobe_pulse;
      strobe_o [*8];
   endsequence

   hold_disable_a: assert property (@(posedge core_clk_i) // R19
      disable iff (sys_rst_i)
      state == ST_HOLD |-> driver_disable_o && !strobe_o)
      else $error("drivers enabled during reset hold");
   enable_strobe_a: assert property (@(posedge core_clk_i) // R21
      disable iff (sys_rst_i)
      $fell(driver_disable_o) |-> $rose(strobe_o) && !rd_op)
      else $error("drivers enabled without update strobe");
   enable_sticky_a: assert property (@(posedge core_clk_i) // R21
      disable iff (sys_rst_i)
      !driver_disable_o |=> !driver_disable_o)
      else $error("drivers disabled again without reset");
   relay_count_a: assert property (@(posedge core_clk_i) // R06
      disable iff (sys_rst_i)
      $rose(strobe_o) && !rd_op |-> rclk_n == 6'd40 && oclk_n == 6'd16)
      else $error("wrong number of shift clocks before strobe");
   strobe_width_a: assert property (@(posedge core_clk_i) // R08
      disable iff (sys_rst_i)
      $rose(strobe_o) |-> strobe_pulse)
      else $error("strobe pulse too short");
   shift_data_a: assert property (@(posedge core_clk_i) // R24
      disable iff (sys_rst_i)
      $changed(out_serial_data_o)
         |-> !relay_shift_clock_o && !output_channel_shift_clock_o)
      else $error("shift data moved while clock high");
   in_count_a: assert property (@(posedge core_clk_i) // R16
      disable iff (sys_rst_i)
      in_valid_o |-> $past(iclk_n) == 6'd16)
      else $error("input read without sixteen clocks");
endmodule

/* include/card_pkg.sv */
// Constants shared by the relay and digital I/O card controller
package card_pkg;
   localparam int CLK_PERIOD_NS    = 4;
   // Link shift clocks: 160 ns period
   localparam int SHIFT_HALF_NS    = 80;
   localparam int SHIFT_HALF_CYC   =
      (SHIFT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Identification clock: 2 us period, keeps the power-up read short
   localparam int ID_HALF_NS       = 1000;
   localparam int ID_HALF_CYC      =
      (ID_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Processor reset hold before the safeguard preset is released
   localparam int PRESET_HOLD_MS   = 200;
   localparam int PRESET_HOLD_CYC  =
      PRESET_HOLD_MS * 1000000 / CLK_PERIOD_NS;
   localparam int TMR_W            = 11;
   localparam int HOLD_W           = 26;
   localparam logic [TMR_W-1:0] SHIFT_HALF_LOAD =
      TMR_W'(SHIFT_HALF_CYC - 1);
   localparam logic [TMR_W-1:0] ID_HALF_LOAD = TMR_W'(ID_HALF_CYC - 1);
   localparam int RELAY_BYTES      = 5;
   localparam int OUT_BYTES        = 2;
   localparam int IN_BYTES         = 2;
   localparam int RELAY_BITS       = RELAY_BYTES * 8;
   localparam int OUT_BITS         = OUT_BYTES * 8;
   localparam int IN_BITS          = IN_BYTES * 8;
   localparam int CHAIN_BITS       = RELAY_BITS + OUT_BITS;
   localparam int ID_BYTES         = 16;
   localparam logic [4:0] ID_LAST  = 5'(ID_BYTES - 1);
   localparam logic [6:0] ID_FIRST_LOC = 7'h00;
   localparam logic       ID_READ_BIT  = 1'h1;
endpackage

/* include/id_link_if.sv */
// Handshake between the controller and its identification reader
`timescale 1ns/1ps
interface id_link_if;
   logic       start;
   logic       busy;
   logic       done;
   logic       fail;
   logic       byte_vld;
   logic [7:0] byte_data;
   modport ctrl   (output start, input busy, done, fail, byte_vld,
                   byte_data);
   modport reader (input start, output busy, done, fail, byte_vld,
                   byte_data);
endinterface

/* logic/id_reader.sv */
// Two-wire master that fetches the card identification record
`timescale 1ns/1ps
module id_reader (
   input  wire logic  core_clk_i,
   input  wire logic  sys_rst_i,
   input  wire logic  sda_i,
   output logic       scl_o,
   output logic       sda_oe_o,
   id_link_if.reader  lnk
);
   typedef enum logic [2:0] {RD_IDLE, RD_START, RD_TX, RD_RX, RD_STOP,
                             RD_DONE} rd_state_t;
   rd_state_t                  state, next_state;
   logic [card_pkg::TMR_W-1:0] tmr, next_tmr;
   logic                       half, next_half;
   logic [3:0]                 bit_cnt, next_bit;
   logic [7:0]                 tx, next_tx;
   logic [7:0]                 rx, next_rx;
   logic [4:0]                 cnt, next_cnt;
   logic                       fail, next_fail;
   logic                       vld, next_vld;
   logic                       next_scl, next_oe;
   logic                       tick, last;

   assign tick = (tmr == '0);
   assign last = (cnt == card_pkg::ID_LAST);
   assign lnk.busy = (state != RD_IDLE) && (state != RD_DONE);
   assign lnk.done = (state == RD_DONE);
   assign lnk.fail = fail;
   assign lnk.byte_vld = vld;
   assign lnk.byte_data = rx;

   always_comb begin
      next_state = state;
      next_tmr = tmr;
      next_half = half;
      next_bit = bit_cnt;
      next_tx = tx;
      next_rx = rx;
      next_cnt = cnt;
      next_fail = fail;
      next_vld = 1'b0;
      next_scl = scl_o;
      next_oe = sda_oe_o;
      if (!lnk.busy)
         next_tmr = card_pkg::ID_HALF_LOAD;
      else if (tick)
         next_tmr = card_pkg::ID_HALF_LOAD;
      else
         next_tmr = tmr - 1'b1;
      case (state)
         RD_IDLE, RD_DONE: begin
            if (lnk.start) begin
               // Data falls while the clock stays high
               next_state = RD_START; // R02
               next_oe = 1'b1;
               next_tx = {card_pkg::ID_FIRST_LOC, card_pkg::ID_READ_BIT};
               next_cnt = '0;
               next_fail = 1'b0;
            end
         end
         RD_START: begin
            if (tick) begin
               next_state = RD_TX; // R03
               next_scl = 1'b0;
               next_half = 1'b0;
               next_bit = '0;
               next_oe = ~tx[7]; // R23
               next_tx = {tx[6:0], 1'b0};
            end
         end
         RD_TX, RD_RX: begin
            if (tick && !half) begin
               next_scl = 1'b1;
               next_half = 1'b1;
            end else if (tick) begin
               next_scl = 1'b0;
               next_half = 1'b0;
               next_bit = bit_cnt + 1'b1;
               if (bit_cnt == 4'h8) begin
                  next_bit = '0;
                  if (state == RD_TX) begin
                     // Missing acknowledge ends the read with a stop
                     next_fail = sda_i;
                     next_state = sda_i ? RD_STOP : RD_RX; // R03
                     next_oe = sda_i;
                  end else begin
                     next_vld = 1'b1;
                     next_cnt = cnt + 1'b1; // R04
                     next_state = last ? RD_STOP : RD_RX; // R05
                     next_oe = last;
                  end
               end else if (state == RD_TX) begin
                  next_oe = (bit_cnt == 4'h7) ? 1'b0 : ~tx[7]; // R23
                  next_tx = {tx[6:0], 1'b0};
               end else begin
                  next_rx = {rx[6:0], sda_i}; // R23
                  // Acknowledge every byte but the last one
                  next_oe = (bit_cnt == 4'h7) ? !last : 1'b0; // R04
               end
            end
         end
         RD_STOP: begin
            if (tick && !half) begin
               next_scl = 1'b1;
               next_half = 1'b1;
            end else if (tick) begin
               next_oe = 1'b0; // R05
               next_state = RD_DONE;
            end
         end
         default: next_state = RD_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state <= RD_IDLE;
         tmr <= card_pkg::ID_HALF_LOAD;
         half <= 1'b0;
         bit_cnt <= '0;
         tx <= '0;
         rx <= '0;
         cnt <= '0;
         fail <= 1'b0;
         vld <= 1'b0;
         scl_o <= 1'b1;
         sda_oe_o <= 1'b0;
      end else begin
         state <= next_state;
         tmr <= next_tmr;
         half <= next_half;
         bit_cnt <= next_bit;
         tx <= next_tx;
         rx <= next_rx;
         cnt <= next_cnt;
         fail <= next_fail;
         vld <= next_vld;
         scl_o <= next_scl;
         sda_oe_o <= next_oe;
      end
   end

   sda_high_clk_a: assert property (@(posedge core_clk_i) // R23
      disable iff (sys_rst_i)
      $changed(sda_oe_o) && scl_o && $past(scl_o)
         |-> state == RD_START || state == RD_DONE)
      else $error("id data moved while id clock high");
   ack_then_rx_a: assert property (@(posedge core_clk_i) // R03
      disable iff (sys_rst_i)
      $rose(state == RD_RX) |-> $past(state) == RD_TX && !$past(sda_i))
      else $error("data phase entered without acknowledge");
   stop_cond_a: assert property (@(posedge core_clk_i) // R05
      disable iff (sys_rst_i)
      $rose(state == RD_DONE) |-> scl_o && $past(sda_oe_o) && !sda_oe_o)
      else $error("stop condition malformed");
endmodule

/* testbench/card_model.sv */
// Behavioural card: id memory, driver chains and input chain
`timescale 1ns/1ps
module card_model (
   input  wire logic        scl_i,
   input  wire logic        host_oe_i,
   output logic             sda_o,
   input  wire logic        data_i,
   input  wire logic        relay_clk_i,
   input  wire logic        out_clk_i,
   input  wire logic        in_clk_i,
   input  wire logic        strobe_i,
   input  wire logic        disable_i,
   input  wire logic [15:0] in_ch_i,
   output logic             in_data_o,
   output logic      [39:0] relay_n_o,
   output logic      [15:0] chan_o,
   output logic      [7:0]  addr_o,
   output logic             boost_o
);
   logic [39:0] rsh = '0;
   logic [39:0] rlat = '0;
   logic [15:0] osh = '0;
   logic [15:0] olat = '0;
   logic [15:0] ish = '0;
   logic [7:0]  sh;
   logic [7:0]  cur;
   logic [3:0]  loc;
   logic        mem_oe = 1'b0;
   logic        act = 1'b0;
   logic        rd;
   logic        ack;
   int          bitn;
   function automatic logic [7:0] rom(input logic [3:0] a);
      return 8'hc3 ^ {a, ~a};
   endfunction
   // Pull-up on the open-drain id line
   assign sda_o = !(host_oe_i || mem_oe);
   // Let a clock edge of the same time step settle before judging
   always @(negedge sda_o) begin
      #1;
      if (scl_i) begin
         act = 1'b1;
         rd = 1'b0;
         bitn = -1;
      end
   end
   always @(posedge sda_o) begin
      #1;
      if (scl_i) act = 1'b0;
   end
   // Relay supply raised for about 100 ms after a closing strobe
   initial boost_o = 1'b0;
   always @(posedge strobe_i) if (|(rsh & ~rlat)) begin
      boost_o = 1'b1;
      #100000000 boost_o = 1'b0;
   end
   always @(posedge scl_i) if (act) begin
      if (!rd && bitn < 8) sh = {sh[6:0], sda_o};
      if (rd && bitn == 8) ack = !sda_o;
   end
   always @(negedge scl_i) if (act) begin
      if (bitn == 8) begin
         bitn = 0;
         if (!rd) begin
            rd = 1'b1;
            loc = sh[4:1];
            addr_o = sh;
         end else if (ack) loc = loc + 4'h1;
         else act = 1'b0;
         cur = rom(loc);
         mem_oe = act && !cur[7];
      end else begin
         bitn++;
         cur = rom(loc) << bitn;
         mem_oe = (bitn == 8) ? !rd : (rd && !cur[7]);
      end
   end
   always @(posedge relay_clk_i) rsh <= {rsh[38:0], data_i};
   always @(posedge out_clk_i) osh <= {osh[14:0], data_i};
   always @(posedge in_clk_i) ish <= {ish[14:0], 1'b0};
   always @(posedge strobe_i) begin
      rlat <= rsh;
      olat <= osh;
      ish <= in_ch_i;
   end
   assign in_data_o = ish[15];
   assign relay_n_o = disable_i ? '1 : ~rlat;
   assign chan_o = disable_i ? '0 : olat;
endmodule

/* testbench/serial_relay_io_card_control_test.sv */
// Self-checking bench for the card controller against the card model
`timescale 1ns/1ps
module serial_relay_io_card_control_test;
   logic        core_clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        update_i = 1'b0;
   logic        read_in_i = 1'b0;
   logic [39:0] relay_pattern_i = '0;
   logic [15:0] out_pattern_i = '0;
   logic [15:0] in_ch = 16'hc35a;
   logic [3:0]  id_rd_addr_i = '0;
   logic [7:0]  id_rd_data_o;
   logic [7:0]  addr_seen;
   logic        id_ready_o, id_error_o, busy_o, in_valid_o, disable_o;
   logic        strobe_o, scl, sda, sda_oe, sdo, rclk, oclk, iclk, isd;
   logic        sda_out, boost;
   logic [15:0] in_data_o;
   logic [15:0] chan;
   logic [39:0] relay_n;
   int          err_total = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   int          strobes = 0;
   int          rcnt = 0;
   int          ocnt = 0;
   initial forever #2 core_clk_i = ~core_clk_i;
   always @(posedge strobe_o) strobes++;
   always @(posedge rclk) rcnt++;
   always @(posedge oclk) ocnt++;
   card_ctrl_host #(.HOLD_CYCLES(20)) dut (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .relay_pattern_i(relay_pattern_i), .out_pattern_i(out_pattern_i),
      .update_i(update_i), .read_in_i(read_in_i),
      .id_rd_addr_i(id_rd_addr_i), .id_rd_data_o(id_rd_data_o),
      .id_ready_o(id_ready_o), .id_error_o(id_error_o), .busy_o(busy_o),
      .in_data_o(in_data_o), .in_valid_o(in_valid_o),
      .driver_disable_o(disable_o), .strobe_o(strobe_o),
      .id_serial_clock_o(scl), .id_serial_data_i(sda),
      .id_serial_data_o(sda_out), .id_serial_data_oe_o(sda_oe),
      .out_serial_data_o(sdo), .relay_shift_clock_o(rclk),
      .output_channel_shift_clock_o(oclk), .input_shift_clock_o(iclk),
      .in_serial_data_i(isd));
   card_model card (
      .scl_i(scl), .host_oe_i(sda_oe), .sda_o(sda), .data_i(sdo),
      .relay_clk_i(rclk), .out_clk_i(oclk), .in_clk_i(iclk),
      .strobe_i(strobe_o), .disable_i(disable_o), .in_ch_i(in_ch),
      .in_data_o(isd), .relay_n_o(relay_n), .chan_o(chan),
      .addr_o(addr_seen), .boost_o(boost));
   task automatic chk(input string what, input logic [39:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic idle_wait;
      @(posedge core_clk_i);
      while (busy_o !== 1'b0) @(posedge core_clk_i);
   endtask
   task automatic pulse(input bit upd);
      if (upd) update_i <= 1'b1;
      else read_in_i <= 1'b1;
      @(posedge core_clk_i);
      update_i <= 1'b0;
      read_in_i <= 1'b0;
   endtask
   task automatic test_power_up;
      relay_pattern_i <= 40'hff_0000_00ff;
      pulse(1'b1); // Refused: still busy in hold
      while (id_ready_o !== 1'b1) @(posedge core_clk_i);
      chk("id error", id_error_o, 1'b0);
      chk("location byte", addr_seen,
          {card_pkg::ID_FIRST_LOC, card_pkg::ID_READ_BIT});
      chk("disable after hold", disable_o, 1'b1);
      chk("strobes before ready", strobes, 0);
      chk("boost before update", boost, 1'b0);
      chk("id data out", sda_out, 1'b0);
      for (int i = 0; i < 16; i++) begin
         id_rd_addr_i <= 4'(i);
         repeat (2) @(posedge core_clk_i);
         chk("id byte", id_rd_data_o, 8'hc3 ^ {4'(i), ~4'(i)});
      end
      $display("power-up test done");
   endtask
   task automatic test_input_read(input logic [15:0] ch, input logic dis);
      in_ch <= ch;
      idle_wait();
      pulse(1'b0);
      do @(posedge core_clk_i); while (in_valid_o !== 1'b1);
      chk("input word", in_data_o, ch);
      chk("disable after read", disable_o, dis);
      $display("input read test done");
   endtask
   task automatic test_update(input logic [39:0] r, input logic [15:0] o);
      int r0;
      int o0;
      r0 = rcnt;
      o0 = ocnt;
      idle_wait();
      relay_pattern_i <= r;
      out_pattern_i <= o;
      pulse(1'b1);
      idle_wait();
      chk("relay clocks", rcnt - r0, 40);
      chk("output clocks", ocnt - o0, 16);
      chk("relay drivers", relay_n, ~r);
      chk("output channels", chan, o);
      chk("disable after update", disable_o, 1'b0);
      chk("relay boost", boost, 1'b1);
      $display("update test done");
   endtask
   task automatic test_reset;
      sys_rst_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      chk("disable in reset", disable_o, 1'b1);
      chk("relays in reset", relay_n, '1);
      chk("channels in reset", chan, 16'h0000);
      $display("reset test done");
   endtask
   // Id read alone runs near 77k cycles at the fixed id clock rate
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 95000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      repeat (3) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      test_power_up();
      test_input_read(16'hc35a, 1'b1);
      test_update(40'h80_a5c3_0f01, 16'h8001);
      test_update(40'hff_ffff_ffff, 16'h0000);
      test_input_read(16'h5a3c, 1'b0);
      test_reset();
      conclude();
   end
endmodule
